// *** common/mac_tx_policy_pkg.sv ***
// constants for the half-duplex transmit policy and phy control block
package mac_tx_policy_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // one nibble time at 10 Mbit/s
  localparam int NIBBLE_TIME_NS = 400;
  localparam int NIBBLE_CYCLES = (NIBBLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // 512 bit times
  localparam int SLOT_TIME_NS = 51200;
  localparam int SLOT_CYCLES_DEF = (SLOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // excessive deferral: 3036 byte times
  localparam int DEFER_LIMIT_NS = 2428800;
  localparam int DEFER_CYCLES_DEF = DEFER_LIMIT_NS / CLK_PERIOD_NS;
  localparam int MAX_ATTEMPTS = 16;
  localparam int BACKOFF_MAX_EXP = 10;

  localparam logic [3:0] ADDR_MAC_CONTROL_THREE = 4'h0;
  localparam logic [3:0] ADDR_BACK_TO_BACK_GAP = 4'h1;
  localparam logic [3:0] ADDR_PHY_CONTROL_TWO = 4'h2;
  localparam logic [3:0] ADDR_PHY_CONTROL_ONE = 4'h3;
  localparam logic [3:0] ADDR_MAC_DUPLEX = 4'h4;
  localparam logic [3:0] ADDR_TX_STATUS = 4'h5;

  // mac_control_three fields
  localparam int DEFER_BIT = 6;
  localparam int BACKPRESSURE_NO_BACKOFF_BIT = 5;
  localparam int SKIP_BACKOFF_BIT = 4;
  localparam logic [7:0] MAC_CONTROL_THREE_MASK = 8'h70;
  localparam logic [7:0] MAC_CONTROL_THREE_RESET = 8'h00;
  // back_to_back_gap fields
  localparam logic [7:0] BACK_TO_BACK_GAP_MASK = 8'h7F;
  localparam logic [7:0] BACK_TO_BACK_GAP_RESET = 8'h00;
  localparam logic [7:0] GAP_OFFSET_FULL = 8'h03;
  localparam logic [7:0] GAP_OFFSET_HALF = 8'h06;
  // phy_control_two fields
  localparam int FORCE_LINK_UP_BIT = 14;
  localparam int TWISTED_PAIR_TX_OFF_BIT = 13;
  localparam int JABBER_OFF_BIT = 10;
  localparam int HALF_DUPLEX_LOOPBACK_DISABLE_BIT = 8;
  localparam logic [15:0] PHY_CONTROL_TWO_MASK = 16'h6500;
  localparam logic [15:0] PHY_CONTROL_TWO_RESET = 16'h0000;
  // phy_control_one fields
  localparam int PHY_LOOPBACK_BIT = 14;
  localparam int PHY_DUPLEX_MODE_BIT = 8;
  localparam logic [15:0] PHY_CONTROL_ONE_MASK = 16'h4100;
  localparam logic [15:0] PHY_CONTROL_ONE_RESET = 16'h0000;
  // mac_duplex: bit 0 is mac_full_duplex
  localparam logic [15:0] MAC_DUPLEX_RESET = 16'h0000;
  // tx_status: write 1 to bits 1..2 clears the sticky abort flags
  localparam int STAT_DEFER_ABORT_BIT = 1;
  localparam int STAT_RETRY_ABORT_BIT = 2;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEFER,
    ST_XMIT,
    ST_BACKOFF
  } tx_state_t;
endpackage : mac_tx_policy_pkg

// *** rtl/mac_tx_gap_backoff_phy_ctrl.sv ***
// transmit gap, deferral and backoff policy with phy control bits
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - defer set: wait forever for free medium
// - skip backoff: retry immediately after collisions
// - full duplex gap is value plus three
// - half duplex gap is value plus six
// - gap register top bit reads zero
// - force link bit reports link up
// - transmitter disable bit silences twisted pair
// - jabber bit turns jabber correction off
// - loopback disable ignored in loopback or full
// - loopback disable: data to twisted pair only
// - loopback enabled: data to mac and pair
// - phy control two top bit reads zero
module mac_tx_gap_backoff_phy_ctrl
  import mac_tx_policy_pkg::*;
#(
  parameter int SLOT_CYCLES = SLOT_CYCLES_DEF,
  parameter int DEFER_CYCLES = DEFER_CYCLES_DEF
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic tx_request_i,
  input wire logic tx_end_i,
  input wire logic backpressure_i,
  input wire logic medium_busy_i,
  input wire logic collision_i,
  input wire logic link_detect_i,
  input wire logic duplex_strap_i,
  output logic tx_start_o,
  output logic tx_done_o,
  output logic tx_abort_o,
  output logic transmitting_o,
  output logic link_up_o,
  output logic tp_tx_enable_o,
  output logic jabber_correct_o,
  output logic loopback_to_mac_o
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [3:0] pin_meta_reg;
  logic [3:0] pin_sync_reg;
  always_ff @(posedge clk_i) begin
    pin_meta_reg <= {duplex_strap_i, link_detect_i, collision_i, medium_busy_i};
    pin_sync_reg <= pin_meta_reg;
  end
  wire logic busy_s = pin_sync_reg[0];
  wire logic coll_s = pin_sync_reg[1];
  wire logic link_s = pin_sync_reg[2];
  wire logic strap_s = pin_sync_reg[3];

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] mac3_reg;
  logic [7:0] gap_reg;
  logic [15:0] phy2_reg;
  logic [15:0] phy1_reg;
  logic mac_full_duplex_reg;
  logic strap_taken_reg;
  logic defer_abort_reg;
  logic retry_abort_reg;
  logic [15:0] rdata_reg;
  tx_state_t state_reg;
  logic [4:0] attempts_reg;

  wire logic wr_mac3 = wr_i && (addr_i == ADDR_MAC_CONTROL_THREE);
  wire logic wr_gap = wr_i && (addr_i == ADDR_BACK_TO_BACK_GAP);
  wire logic wr_phy2 = wr_i && (addr_i == ADDR_PHY_CONTROL_TWO);
  wire logic wr_phy1 = wr_i && (addr_i == ADDR_PHY_CONTROL_ONE);
  wire logic wr_dpx = wr_i && (addr_i == ADDR_MAC_DUPLEX);
  wire logic wr_stat = wr_i && (addr_i == ADDR_TX_STATUS);

  wire logic defer_en = mac3_reg[DEFER_BIT];
  wire logic bp_no_backoff = mac3_reg[BACKPRESSURE_NO_BACKOFF_BIT];
  wire logic skip_backoff = mac3_reg[SKIP_BACKOFF_BIT];
  wire logic half_duplex = !mac_full_duplex_reg;
  // phy and mac duplex must agree; mismatch is visible to software
  wire logic duplex_mismatch = phy1_reg[PHY_DUPLEX_MODE_BIT] != mac_full_duplex_reg;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      mac3_reg <= MAC_CONTROL_THREE_RESET;
      gap_reg <= BACK_TO_BACK_GAP_RESET;
      phy2_reg <= PHY_CONTROL_TWO_RESET;
      mac_full_duplex_reg <= 1'b0;
    end else begin
      // unimplemented and reserved bits never store
      if (wr_mac3) mac3_reg <= wdata_i[7:0] & MAC_CONTROL_THREE_MASK;
      if (wr_gap) gap_reg <= wdata_i[7:0] & BACK_TO_BACK_GAP_MASK;
      if (wr_phy2) phy2_reg <= wdata_i & PHY_CONTROL_TWO_MASK;
      if (wr_dpx) mac_full_duplex_reg <= wdata_i[0];
    end
  end

  // duplex strap is caught once, after reset release
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      phy1_reg <= PHY_CONTROL_ONE_RESET;
      strap_taken_reg <= 1'b0;
    end else if (wr_phy1) begin
      phy1_reg <= wdata_i & PHY_CONTROL_ONE_MASK;
      strap_taken_reg <= 1'b1;
    end else if (!strap_taken_reg) begin
      phy1_reg[PHY_DUPLEX_MODE_BIT] <= strap_s;
      strap_taken_reg <= 1'b1;
    end
  end

  wire logic [15:0] status_word = {8'h00, 3'h0, attempts_reg[3:0] == 4'h0 ? 1'b0 : 1'b1,
                                   duplex_mismatch, retry_abort_reg, defer_abort_reg, transmitting_o};
  logic [15:0] read_mux;
  always_comb begin
    read_mux = 16'h0000;
    unique case (addr_i)
      ADDR_MAC_CONTROL_THREE: read_mux = {8'h00, mac3_reg};
      ADDR_BACK_TO_BACK_GAP: read_mux = {8'h00, gap_reg};
      ADDR_PHY_CONTROL_TWO: read_mux = phy2_reg;
      ADDR_PHY_CONTROL_ONE: read_mux = phy1_reg;
      ADDR_MAC_DUPLEX: read_mux = {15'h0000, mac_full_duplex_reg};
      ADDR_TX_STATUS: read_mux = status_word;
      default: read_mux = 16'h0000;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (!resetn_i) rdata_reg <= 16'h0000;
    else if (rd_i) rdata_reg <= read_mux;
    else rdata_reg <= 16'h0000;
  end
  assign rdata_o = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // phy control outputs
  wire logic loop_bits_clear = !phy1_reg[PHY_LOOPBACK_BIT] && !phy1_reg[PHY_DUPLEX_MODE_BIT];
  assign link_up_o = phy2_reg[FORCE_LINK_UP_BIT] || link_s;
  assign tp_tx_enable_o = !phy2_reg[TWISTED_PAIR_TX_OFF_BIT];
  assign jabber_correct_o = !phy2_reg[JABBER_OFF_BIT];
  assign loopback_to_mac_o = loop_bits_clear && !phy2_reg[HALF_DUPLEX_LOOPBACK_DISABLE_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // nibble time enable and inter-packet gap
  logic [7:0] nib_div_reg;
  logic [7:0] gap_cnt_reg;
  wire logic nib_tick = nib_div_reg == 8'(NIBBLE_CYCLES - 1);
  wire logic gap_done = gap_cnt_reg == 8'h00;
  wire logic [7:0] gap_load = gap_reg + (half_duplex ? GAP_OFFSET_HALF : GAP_OFFSET_FULL);
  wire logic frame_end = (state_reg == ST_XMIT) && tx_end_i;

  always_ff @(posedge clk_i) begin
    if (!resetn_i || frame_end) nib_div_reg <= 8'h00;
    else if (nib_tick) nib_div_reg <= 8'h00;
    else nib_div_reg <= nib_div_reg + 8'h01;
  end
  always_ff @(posedge clk_i) begin
    if (!resetn_i) gap_cnt_reg <= 8'h00;
    else if (frame_end) gap_cnt_reg <= gap_load;
    else if (nib_tick && !gap_done) gap_cnt_reg <= gap_cnt_reg - 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // deferral, collision and backoff
  logic [31:0] defer_cnt_reg;
  logic [15:0] slot_cnt_reg;
  logic [9:0] slots_left_reg;
  logic [15:0] lfsr_reg;

  wire logic medium_held = half_duplex && busy_s;
  wire logic defer_limit = defer_cnt_reg == 32'(DEFER_CYCLES - 1);
  wire logic xmit_coll = (state_reg == ST_XMIT) && half_duplex && coll_s && !tx_end_i;
  wire logic last_attempt = attempts_reg == 5'(MAX_ATTEMPTS - 1);
  wire logic retry_now = skip_backoff || (bp_no_backoff && backpressure_i);
  wire logic [3:0] bo_exp = attempts_reg >= 5'(BACKOFF_MAX_EXP) ? 4'(BACKOFF_MAX_EXP) : attempts_reg[3:0] + 4'h1;
  wire logic [9:0] bo_mask = 10'((11'h001 << bo_exp) - 11'h001);
  wire logic slot_end = slot_cnt_reg == 16'(SLOT_CYCLES - 1);
  wire logic can_start = tx_request_i && gap_done && !medium_held;
  wire logic defer_fail = (state_reg == ST_DEFER) && medium_held && !defer_en && defer_limit;
  wire logic retry_fail = xmit_coll && last_attempt;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) lfsr_reg <= 16'hACE1;
    else lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state_reg <= ST_IDLE;
      attempts_reg <= 5'h00;
      defer_cnt_reg <= 32'h0000_0000;
      slot_cnt_reg <= 16'h0000;
      slots_left_reg <= 10'h000;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          defer_cnt_reg <= 32'h0000_0000;
          if (tx_request_i && medium_held) state_reg <= ST_DEFER;
          else if (can_start) state_reg <= ST_XMIT;
        end
        ST_DEFER: begin
          // defer set: no limit applies while the medium stays busy
          if (!tx_request_i || defer_fail) state_reg <= ST_IDLE;
          else if (!medium_held && gap_done) state_reg <= ST_XMIT;
          if (medium_held && !defer_limit) defer_cnt_reg <= defer_cnt_reg + 32'h0000_0001;
        end
        ST_XMIT: begin
          if (tx_end_i) begin
            state_reg <= ST_IDLE;
            attempts_reg <= 5'h00;
          end else if (xmit_coll) begin
            if (last_attempt) begin
              state_reg <= ST_IDLE;
              attempts_reg <= 5'h00;
            end else begin
              attempts_reg <= attempts_reg + 5'h01;
              slot_cnt_reg <= 16'h0000;
              slots_left_reg <= lfsr_reg[9:0] & bo_mask;
              state_reg <= retry_now ? ST_IDLE : ST_BACKOFF;
            end
          end
        end
        ST_BACKOFF: begin
          if (slots_left_reg == 10'h000) state_reg <= ST_IDLE;
          else if (slot_end) begin
            slot_cnt_reg <= 16'h0000;
            slots_left_reg <= slots_left_reg - 10'h001;
          end else slot_cnt_reg <= slot_cnt_reg + 16'h0001;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  wire logic start_now = ((state_reg == ST_IDLE) && can_start)
                      || ((state_reg == ST_DEFER) && tx_request_i && !medium_held && gap_done);

  // sticky abort flags: a new abort wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      defer_abort_reg <= 1'b0;
      retry_abort_reg <= 1'b0;
    end else begin
      defer_abort_reg <= defer_fail || (defer_abort_reg && !(wr_stat && wdata_i[STAT_DEFER_ABORT_BIT]));
      retry_abort_reg <= retry_fail || (retry_abort_reg && !(wr_stat && wdata_i[STAT_RETRY_ABORT_BIT]));
    end
  end

  assign tx_start_o = start_now;
  assign tx_done_o = frame_end;
  assign tx_abort_o = defer_fail || retry_fail;
  assign transmitting_o = state_reg == ST_XMIT;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  sequence s_coll_retry_now;
    xmit_coll && !last_attempt && retry_now;
  endsequence
  sequence s_back_in_idle;
    ##1 state_reg == ST_IDLE;
  endsequence

  AST_DEFER_NO_ABORT: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (state_reg == ST_DEFER) && defer_en |-> !tx_abort_o)
    else $error("abort while indefinite deferral enabled");
  AST_DEFER_LIMIT_ABORT: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (state_reg == ST_DEFER) && medium_held && !defer_en && defer_limit && tx_request_i
      |-> tx_abort_o ##1 (state_reg == ST_IDLE && defer_abort_reg))
    else $error("excessive deferral did not abort");
  AST_IMMEDIATE_RETRY: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_coll_retry_now |-> s_back_in_idle)
    else $error("no immediate retry after collision");
  AST_BACKOFF_USED: assert property (@(posedge clk_i) disable iff (!resetn_i)
    xmit_coll && !last_attempt && !skip_backoff && !(bp_no_backoff && backpressure_i)
      |=> state_reg == ST_BACKOFF)
    else $error("backoff skipped with option clear");
  AST_GAP_LOAD: assert property (@(posedge clk_i) disable iff (!resetn_i)
    frame_end |=> gap_cnt_reg == $past(gap_reg) + ($past(half_duplex) ? 8'h06 : 8'h03))
    else $error("gap load wrong");
  AST_NO_START_IN_GAP: assert property (@(posedge clk_i) disable iff (!resetn_i)
    frame_end ##1 tx_request_i [*3] |-> !tx_start_o)
    else $error("start inside inter-packet gap");
  AST_GAP_TOP_ZERO: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rd_i && addr_i == ADDR_BACK_TO_BACK_GAP |=> rdata_o[7] == 1'b0)
    else $error("gap top bit read as one");
  AST_FORCE_LINK: assert property (@(posedge clk_i) disable iff (!resetn_i)
    phy2_reg[FORCE_LINK_UP_BIT] |-> link_up_o)
    else $error("forced link not reported");
  AST_TX_OFF: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr_phy2 && wdata_i[TWISTED_PAIR_TX_OFF_BIT] |=> !tp_tx_enable_o)
    else $error("transmitter not disabled");
  AST_JABBER_OFF: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr_phy2 |=> jabber_correct_o == !$past(wdata_i[JABBER_OFF_BIT]))
    else $error("jabber correction control wrong");
  AST_LOOP_IGNORED: assert property (@(posedge clk_i) disable iff (!resetn_i)
    phy1_reg[PHY_LOOPBACK_BIT] || phy1_reg[PHY_DUPLEX_MODE_BIT] |-> !loopback_to_mac_o)
    else $error("loopback active while disable bit ignored");
  AST_LOOP_SELECT: assert property (@(posedge clk_i) disable iff (!resetn_i)
    loop_bits_clear |-> loopback_to_mac_o != phy2_reg[HALF_DUPLEX_LOOPBACK_DISABLE_BIT])
    else $error("loopback select wrong");
  AST_PHY2_TOP_ZERO: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rd_i && addr_i == ADDR_PHY_CONTROL_TWO |=> rdata_o[15] == 1'b0)
    else $error("phy control two top bit read as one");

endmodule : mac_tx_gap_backoff_phy_ctrl
`default_nettype wire

// *** sim/link_partner_model.sv ***
// behavioural twisted-pair link partner driving the line-side pins
`timescale 1ns/100ps
`default_nettype none
module link_partner_model (
  input wire logic clk_i,
  input wire logic carrier_cmd_i,
  input wire logic collide_cmd_i,
  input wire logic link_cmd_i,
  input wire logic tp_tx_enable_i,
  output logic medium_busy_o,
  output logic collision_o,
  output logic link_detect_o
);
  // a silenced transmitter cannot collide with our frames
  always_ff @(posedge clk_i) begin
    medium_busy_o <= carrier_cmd_i;
    collision_o <= collide_cmd_i & tp_tx_enable_i;
    link_detect_o <= link_cmd_i;
  end
endmodule : link_partner_model
`default_nettype wire

// *** sim/test_mac_tx_gap_backoff_phy_ctrl.sv ***
// self-checking bench for the transmit policy and phy control block
`timescale 1ns/100ps
`default_nettype none
module test_mac_tx_gap_backoff_phy_ctrl;
  import mac_tx_policy_pkg::*;
  localparam int SLOT = 20;
  localparam int DEFER = 50;
  logic clk_i, resetn_i, wr_i, rd_i, tx_request_i, tx_end_i, backpressure_i, duplex_strap_i;
  logic [3:0] addr_i;
  logic [15:0] wdata_i, rdata_o;
  logic carrier_cmd, collide_cmd, link_cmd, medium_busy, collision, link_detect;
  logic tx_start_o, tx_done_o, tx_abort_o, transmitting_o, link_up_o, tp_tx_enable_o, jabber_correct_o;
  logic loopback_to_mac_o;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n;

  mac_tx_gap_backoff_phy_ctrl #(.SLOT_CYCLES(SLOT), .DEFER_CYCLES(DEFER)) uut (.clk_i(clk_i), .resetn_i(resetn_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tx_request_i(tx_request_i),
    .tx_end_i(tx_end_i), .backpressure_i(backpressure_i), .medium_busy_i(medium_busy), .collision_i(collision),
    .link_detect_i(link_detect), .duplex_strap_i(duplex_strap_i), .tx_start_o(tx_start_o), .tx_done_o(tx_done_o),
    .tx_abort_o(tx_abort_o), .transmitting_o(transmitting_o), .link_up_o(link_up_o),
    .tp_tx_enable_o(tp_tx_enable_o), .jabber_correct_o(jabber_correct_o), .loopback_to_mac_o(loopback_to_mac_o));

  link_partner_model partner (.clk_i(clk_i), .carrier_cmd_i(carrier_cmd), .collide_cmd_i(collide_cmd),
    .link_cmd_i(link_cmd), .tp_tx_enable_i(tp_tx_enable_o), .medium_busy_o(medium_busy),
    .collision_o(collision), .link_detect_o(link_detect));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic print_verdict;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  // ceiling well above the few thousand cycles the scenarios need
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      print_verdict();
    end
  end

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : reg_rd

  // cycles until tx_start_o, counted from the calling edge
  task automatic wait_start(input int limit, output int k);
    k = 0;
    #1;
    while (tx_start_o !== 1'b1 && k < limit) begin
      @(posedge clk_i);
      #1;
      k++;
    end
  endtask : wait_start

  // again keeps the request up as the next back-to-back frame
  task automatic end_frame(input logic again);
    @(posedge clk_i);
    tx_end_i <= 1'b1;
    #1 check({15'h0000, transmitting_o}, 16'h0001, "transmitting");
    check({15'h0000, tx_done_o}, 16'h0001, "frame done");
    @(posedge clk_i);
    tx_end_i <= 1'b0;
    tx_request_i <= again;
  endtask : end_frame

  task automatic test_registers;
    logic [15:0] d;
    reg_rd(ADDR_BACK_TO_BACK_GAP, d);
    check(d, 16'h0000, "gap reset");
    reg_rd(ADDR_PHY_CONTROL_TWO, d);
    check(d, 16'h0000, "phy2 reset");
    reg_wr(ADDR_MAC_CONTROL_THREE, 16'h00FC);
    reg_rd(ADDR_MAC_CONTROL_THREE, d);
    check(d, 16'h0070, "mac3 reserved");
    reg_wr(ADDR_BACK_TO_BACK_GAP, 16'h00FF);
    reg_rd(ADDR_BACK_TO_BACK_GAP, d);
    check(d, 16'h007F, "gap top bit");
    reg_wr(ADDR_PHY_CONTROL_TWO, 16'hE500);
    reg_rd(ADDR_PHY_CONTROL_TWO, d);
    check(d, 16'h6500, "phy2 top bit");
    reg_wr(4'hF, 16'hFFFF);
    reg_rd(4'hF, d);
    check(d, 16'h0000, "unmapped");
  endtask : test_registers

  task automatic test_phy_bits;
    reg_wr(ADDR_PHY_CONTROL_TWO, 16'h0000);
    repeat (4) @(posedge clk_i);
    #1 check({13'h0000, link_up_o, tp_tx_enable_o, jabber_correct_o}, 16'h0003, "phy normal");
    link_cmd <= 1'b1;
    repeat (4) @(posedge clk_i);
    #1 check({15'h0000, link_up_o}, 16'h0001, "link follows detect");
    link_cmd <= 1'b0;
    reg_wr(ADDR_PHY_CONTROL_TWO, 16'h6400);
    #1 check({13'h0000, link_up_o, tp_tx_enable_o, jabber_correct_o}, 16'h0004, "phy forced");
    check({15'h0000, jabber_correct_o}, 16'h0000, "jabber off");
    reg_wr(ADDR_PHY_CONTROL_ONE, 16'h0000);
    reg_wr(ADDR_PHY_CONTROL_TWO, 16'h0000);
    #1 check({15'h0000, loopback_to_mac_o}, 16'h0001, "loop on");
    reg_wr(ADDR_PHY_CONTROL_TWO, 16'h0100);
    #1 check({15'h0000, loopback_to_mac_o}, 16'h0000, "loop off");
    reg_wr(ADDR_PHY_CONTROL_TWO, 16'h0000);
    reg_wr(ADDR_PHY_CONTROL_ONE, 16'h0100);
    #1 check({15'h0000, loopback_to_mac_o}, 16'h0000, "full duplex");
    reg_wr(ADDR_PHY_CONTROL_ONE, 16'h4000);
    #1 check({15'h0000, loopback_to_mac_o}, 16'h0000, "phy loopback");
    reg_wr(ADDR_PHY_CONTROL_ONE, 16'h0000);
  endtask : test_phy_bits

  // two back-to-back frames; the second waits (gap + offset) nibbles
  task automatic test_gap(input logic full, input logic [7:0] g, input int off);
    int exp;
    reg_wr(ADDR_MAC_DUPLEX, {15'h0000, full});
    reg_wr(ADDR_PHY_CONTROL_ONE, {7'h00, full, 8'h00});
    reg_wr(ADDR_MAC_CONTROL_THREE, 16'h0000);
    reg_wr(ADDR_BACK_TO_BACK_GAP, {8'h00, g});
    tx_request_i <= 1'b1;
    wait_start(1000, n);
    end_frame(1'b1);
    wait_start(1000, n);
    exp = (int'(g) + off) * NIBBLE_CYCLES;
    check({15'h0000, (n >= exp - 1 && n <= exp + 2)}, 16'h0001, "gap length");
    end_frame(1'b0);
  endtask : test_gap

  task automatic test_defer;
    logic [15:0] d;
    // the last frame's gap must run out, or the start after deferral is held back
    repeat (8 * NIBBLE_CYCLES) @(posedge clk_i);
    reg_wr(ADDR_MAC_DUPLEX, 16'h0000);
    reg_wr(ADDR_MAC_CONTROL_THREE, 16'h0000);
    carrier_cmd <= 1'b1;
    repeat (4) @(posedge clk_i);
    tx_request_i <= 1'b1;
    n = 0;
    while (tx_abort_o !== 1'b1 && n < DEFER + 20) begin
      @(posedge clk_i);
      #1 n++;
    end
    check({15'h0000, tx_abort_o}, 16'h0001, "deferral abort");
    @(posedge clk_i);
    tx_request_i <= 1'b0;
    reg_rd(ADDR_TX_STATUS, d);
    check(d, 16'h0002, "deferral abort flag");
    reg_wr(ADDR_TX_STATUS, 16'h0002);
    reg_rd(ADDR_TX_STATUS, d);
    check(d, 16'h0000, "abort flag cleared");
    reg_wr(ADDR_MAC_CONTROL_THREE, 16'h0040);
    tx_request_i <= 1'b1;
    n = 0;
    repeat (3 * DEFER) begin
      @(posedge clk_i);
      #1 n += int'(tx_abort_o === 1'b1 || tx_start_o === 1'b1);
    end
    check(n[15:0], 16'h0000, "waits on busy medium");
    carrier_cmd <= 1'b0;
    wait_start(10, n);
    check({15'h0000, tx_start_o}, 16'h0001, "starts when free");
    end_frame(1'b0);
  endtask : test_defer

  // a collision in mid-frame: prompt retry when an option allows it, else backoff first
  task automatic test_retry(input logic [15:0] ctl, input logic bp, input logic quick);
    reg_wr(ADDR_MAC_CONTROL_THREE, ctl);
    backpressure_i <= bp;
    tx_request_i <= 1'b1;
    wait_start(1000, n);
    @(posedge clk_i);
    collide_cmd <= 1'b1;
    @(posedge clk_i);
    collide_cmd <= 1'b0;
    repeat (3) @(posedge clk_i);
    wait_start(64, n);
    check({15'h0000, tx_start_o}, 16'h0001, "retry started");
    check({15'h0000, n == 0}, {15'h0000, quick}, "retry without backoff");
    end_frame(1'b0);
    backpressure_i <= 1'b0;
  endtask : test_retry

  initial begin
    resetn_i = 1'b0;
    {wr_i, rd_i, tx_request_i, tx_end_i, backpressure_i, duplex_strap_i} = 6'h00;
    {carrier_cmd, collide_cmd, link_cmd} = 3'h0;
    addr_i = 4'h0;
    wdata_i = 16'h0000;
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    test_registers();
    test_phy_bits();
    test_gap(1'b1, 8'h02, 3);
    test_gap(1'b0, 8'h01, 6);
    test_defer();
    test_retry(16'h0010, 1'b0, 1'b1);
    test_retry(16'h0020, 1'b1, 1'b1);
    test_retry(16'h0000, 1'b1, 1'b0);
    print_verdict();
  end
endmodule : test_mac_tx_gap_backoff_phy_ctrl
`default_nettype wire
